// ==== src/fbtd_decoder.sv ====
// Flash bus transaction decoder: bus cycle capture, sequences and overlays
// Behaviour
// - Three-cycle entry opens erase count overlay
// - Two-cycle load latches erase count sector
// - Overlay read returns latched sector erase count
// - Overlay exit returns to array read mode
// - Three-cycle entry opens partition pointer overlay
// - Two-cycle program writes pointers 0x00-0x04
// - Overlay read returns addressed pointer value
// - Read command 101b returns array word
// - AA/55/F5 sequence switches to legacy serial
// - Write F0h anywhere exits status overlay
// - AA/55/B9 sequence enters deep power-down
// - 70h at 555h then read returns status
// - 71h at 555h clears volatile status
// - AA/55/34 then fourth word programs nonvolatile
`timescale 1ns/1ns
module fbtd_decoder
    import fbtd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Flash bus pins
    input wire logic link_clk_i,
    input wire logic cs_n_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_n_o,
    // Memory array side
    output logic [1:0] die_select_bits_o,
    output logic [ADDR_W-1:0] array_addr_o,
    input wire logic [15:0] array_data_i,
    output logic [ADDR_W-1:0] erase_sector_o,
    input wire logic [15:0] erase_count_i,
    // Status and mode
    input wire logic [15:0] status_event_i,
    output logic [15:0] status_o,
    output logic legacy_serial_o,
    output logic deep_power_down_o,
    output logic [1:0] overlay_o,
    // Nonvolatile program request
    output logic nv_prog_o,
    output logic [15:0] nv_word_o
);
    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    logic [9:0] pins_s;
    logic clk_s;
    logic cs_n_s;
    logic [7:0] dq_s;
    logic clk_prev_q;
    logic edge_w;

    fbtd_sync #(.W(10), .INIT(10'h100)) u_sync (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .pin_i({link_clk_i, cs_n_i, dq_i}),
        .sync_o(pins_s)
    );

    assign clk_s = pins_s[9];
    assign cs_n_s = pins_s[8];
    assign dq_s = pins_s[7:0];
    // Both link edges carry a byte, so any change counts
    assign edge_w = (clk_s != clk_prev_q) && !cs_n_s;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [3:0] cnt_q, cnt_d;
    logic [CW_W-1:0] cw_q, cw_d;
    logic [15:0] wd_q, wd_d;
    logic [15:0] rd_q, rd_d;
    logic [7:0] dq_q, dq_d;
    logic oe_n_q, oe_n_d;
    logic rd_load_q, rd_load_d;
    fbtd_src_t src_q, src_d;
    fbtd_mode_t mode_q, mode_d;
    fbtd_seq_t seq_q, seq_d;
    logic [ADDR_W-1:0] sect_q, sect_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [1:0] die_q, die_d;
    logic [15:0] status_q, status_d;
    logic nvp_q, nvp_d;
    logic [15:0] nvw_q, nvw_d;
    logic [15:0] ptr_q [PTR_COUNT];
    logic ptr_we;
    logic [7:0] ptr_idx_q, ptr_idx_d;

    // Decode inputs, valid at the completing edge
    logic [CW_W-1:0] rd_cw;
    logic [15:0] word;
    logic wr_done;
    logic rd_done;
    logic [7:0] cbyte;
    logic at555;
    logic clr_status;

    assign rd_cw = {cw_q[CW_W-9:0], dq_s};
    assign word = {wd_q[7:0], dq_s};
    assign cbyte = word[7:0];
    assign at555 = cw_q[LOW_ADDR_W-1:0] == ADDR_UNLOCK1;
    assign wr_done = edge_w && cnt_q == CNT_WR_LAST && cw_q[CMD_MSB:CMD_LSB] == CMD_WRITE;
    assign rd_done = edge_w && cnt_q == CNT_CW_LAST && rd_cw[CMD_MSB:CMD_LSB] == CMD_READ;

    // ****************************************************************
    // Byte capture and read drive
    // ****************************************************************
    // Read word is fetched one core cycle after decode so that the array
    // sees a registered address; the host gives one spare edge for it
    always_comb begin
        cnt_d = cnt_q;
        cw_d = cw_q;
        wd_d = wd_q;
        rd_d = rd_q;
        dq_d = dq_q;
        oe_n_d = oe_n_q;
        rd_load_d = rd_done;
        if (cs_n_s) begin
            cnt_d = 4'h0;
            oe_n_d = 1'b1;
        end else if (edge_w) begin
            if (cnt_q != 4'hF) begin
                cnt_d = cnt_q + 4'h1;
            end
            if (cnt_q <= CNT_CW_LAST) begin
                cw_d = {cw_q[CW_W-9:0], dq_s};
            end else if (cw_q[CMD_MSB:CMD_LSB] == CMD_WRITE && cnt_q <= CNT_WR_LAST) begin
                wd_d = word;
            end else if (cw_q[CMD_MSB:CMD_LSB] == CMD_READ) begin
                if (cnt_q == CNT_RD_HIGH) begin
                    dq_d = rd_q[15:8];
                    oe_n_d = 1'b0;
                end else if (cnt_q == CNT_RD_LOW) begin
                    dq_d = rd_q[7:0];
                end else if (cnt_q == CNT_RD_END) begin
                    oe_n_d = 1'b1;
                end
            end
        end
        if (rd_load_q) begin
            case (src_q)
                SRC_STATUS: rd_d = status_q;
                SRC_ECNT: rd_d = erase_count_i;
                SRC_PPTR: rd_d = (ptr_idx_q <= PTR_LAST_OFFSET) ?
                    ptr_q[ptr_idx_q[2:0]] : WORD_RESET;
                default: rd_d = array_data_i;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            clk_prev_q <= 1'b0;
            cnt_q <= 4'h0;
            cw_q <= '0;
            wd_q <= WORD_RESET;
            rd_q <= WORD_RESET;
            dq_q <= BYTE_RESET;
            oe_n_q <= 1'b1;
            rd_load_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
            cnt_q <= cnt_d;
            cw_q <= cw_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            dq_q <= dq_d;
            oe_n_q <= oe_n_d;
            rd_load_q <= rd_load_d;
        end
    end

    // ****************************************************************
    // Transaction decode
    // ****************************************************************
    // Any departure from a listed sequence drops back to idle
    always_comb begin
        mode_d = mode_q;
        seq_d = seq_q;
        src_d = src_q;
        sect_d = sect_q;
        addr_d = addr_q;
        die_d = die_q;
        ptr_idx_d = ptr_idx_q;
        ptr_we = 1'b0;
        clr_status = 1'b0;
        nvp_d = 1'b0;
        nvw_d = nvw_q;
        if (rd_done) begin
            seq_d = SEQ_IDLE;
            die_d = rd_cw[DIE_MSB:DIE_LSB];
            addr_d = rd_cw[ADDR_W-1:0];
            ptr_idx_d = rd_cw[7:0];
            case (mode_q)
                MODE_ECNT: src_d = SRC_ECNT;
                MODE_PPTR: src_d = SRC_PPTR;
                default: src_d = (seq_q == SEQ_STAT) ? SRC_STATUS : SRC_ARRAY;
            endcase
        end else if (wr_done) begin
            seq_d = SEQ_IDLE;
            case (mode_q)
                MODE_ARRAY: begin
                    case (seq_q)
                        SEQ_IDLE: begin
                            if (cbyte == CODE_UNLOCK1 && at555) begin
                                seq_d = SEQ_AA;
                            end else if (cbyte == CODE_READ_STATUS && at555) begin
                                seq_d = SEQ_STAT;
                            end else if (cbyte == CODE_CLEAR_STATUS && at555) begin
                                clr_status = 1'b1;
                            end
                            // F0h anywhere simply leaves the sequence idle
                        end
                        SEQ_AA: begin
                            if (cbyte == CODE_UNLOCK2 &&
                                cw_q[LOW_ADDR_W-1:0] == ADDR_UNLOCK2) begin
                                seq_d = SEQ_55;
                            end
                        end
                        SEQ_55: begin
                            if (cbyte == CODE_LEGACY_SERIAL && at555) begin
                                mode_d = MODE_SERIAL;
                            end else if (cbyte == CODE_DEEP_POWER_DOWN) begin
                                mode_d = MODE_DPD;
                            end else if (cbyte == CODE_NV_PROGRAM && at555) begin
                                seq_d = SEQ_NVP;
                            end else if (cbyte == CODE_ECNT_ENTRY) begin
                                mode_d = MODE_ECNT;
                            end else if (cbyte == CODE_PPTR_ENTRY) begin
                                mode_d = MODE_PPTR;
                            end
                        end
                        SEQ_NVP: begin
                            nvp_d = 1'b1;
                            nvw_d = word;
                        end
                        default: seq_d = SEQ_IDLE;
                    endcase
                end
                MODE_ECNT: begin
                    if (seq_q == SEQ_LOAD) begin
                        sect_d = cw_q[ADDR_W-1:0];
                    end else if (cbyte == CODE_EXIT) begin
                        mode_d = MODE_ARRAY;
                    end else if (cbyte == CODE_LOAD_SECTOR && at555) begin
                        seq_d = SEQ_LOAD;
                    end
                end
                MODE_PPTR: begin
                    if (seq_q == SEQ_PGM) begin
                        ptr_idx_d = cw_q[7:0];
                        ptr_we = cw_q[7:0] <= PTR_LAST_OFFSET;
                    end else if (cbyte == CODE_EXIT) begin
                        mode_d = MODE_ARRAY;
                    end else if (cbyte == CODE_PGM_PTR && at555) begin
                        seq_d = SEQ_PGM;
                    end
                end
                default: seq_d = SEQ_IDLE;
            endcase
        end
        // Events set bits even in the clearing cycle
        status_d = (clr_status ? STATUS_RESET : status_q) | status_event_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mode_q <= MODE_ARRAY;
            seq_q <= SEQ_IDLE;
            src_q <= SRC_ARRAY;
            sect_q <= '0;
            addr_q <= '0;
            die_q <= 2'h0;
            ptr_idx_q <= BYTE_RESET;
            status_q <= STATUS_RESET;
            nvp_q <= 1'b0;
            nvw_q <= WORD_RESET;
        end else begin
            mode_q <= mode_d;
            seq_q <= seq_d;
            src_q <= src_d;
            sect_q <= sect_d;
            addr_q <= addr_d;
            die_q <= die_d;
            ptr_idx_q <= ptr_idx_d;
            status_q <= status_d;
            nvp_q <= nvp_d;
            nvw_q <= nvw_d;
        end
    end

    // ****************************************************************
    // One-time-programmable pointer registers
    // ****************************************************************
    // Programming can only clear bits, as an erased OTP cell would behave
    for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
        logic [15:0] ptr_d;
        always_comb begin
            ptr_d = ptr_q[i];
            if (ptr_we && ptr_idx_d == 8'(i)) begin
                ptr_d = ptr_q[i] & word;
            end
        end
        always_ff @(posedge core_clk_i) begin
            if (!nrst_i) begin
                ptr_q[i] <= PTR_RESET;
            end else begin
                ptr_q[i] <= ptr_d;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign dq_o = dq_q;
    assign dq_oe_n_o = oe_n_q;
    assign die_select_bits_o = die_q;
    assign array_addr_o = addr_q;
    assign erase_sector_o = sect_q;
    assign status_o = status_q;
    assign legacy_serial_o = mode_q == MODE_SERIAL;
    assign deep_power_down_o = mode_q == MODE_DPD;
    assign overlay_o = {mode_q == MODE_PPTR, mode_q == MODE_ECNT};
    assign nv_prog_o = nvp_q;
    assign nv_word_o = nvw_q;
endmodule

// ==== src/fbtd_pkg.sv ====
// Constants and types shared by the flash bus transaction decoder
package fbtd_pkg;
    // ****************************************************************
    // Bus word layout
    // ****************************************************************
    localparam int CW_W = 48;
    localparam int CMD_MSB = 47;
    localparam int CMD_LSB = 45;
    localparam int DIE_MSB = 44;
    localparam int DIE_LSB = 43;
    localparam int TOP_ADDRESS_BIT = 42;
    localparam int ADDR_W = TOP_ADDRESS_BIT + 1;
    localparam int LOW_ADDR_W = 12;
    localparam int PTR_COUNT = 5;

    // ****************************************************************
    // Byte counts within one bus cycle
    // ****************************************************************
    localparam logic [3:0] CNT_CW_LAST = 4'h5;
    localparam logic [3:0] CNT_WR_LAST = 4'h7;
    localparam logic [3:0] CNT_RD_HIGH = 4'h6;
    localparam logic [3:0] CNT_RD_LOW = 4'h7;
    localparam logic [3:0] CNT_RD_END = 4'h8;

    // ****************************************************************
    // Command bits and codes
    // ****************************************************************
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
    localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
    localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_LEGACY_SERIAL = 8'hF5;
    localparam logic [7:0] CODE_EXIT = 8'hF0;
    localparam logic [7:0] CODE_DEEP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] CODE_READ_STATUS = 8'h70;
    localparam logic [7:0] CODE_CLEAR_STATUS = 8'h71;
    localparam logic [7:0] CODE_NV_PROGRAM = 8'h34;
    localparam logic [7:0] CODE_ECNT_ENTRY = 8'h5A;
    localparam logic [7:0] CODE_PPTR_ENTRY = 8'h5B;
    localparam logic [7:0] CODE_LOAD_SECTOR = 8'h5C;
    localparam logic [7:0] CODE_PGM_PTR = 8'h5D;
    localparam logic [7:0] PTR_LAST_OFFSET = 8'h04;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] PTR_RESET = 16'hFFFF;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_ARRAY, MODE_ECNT, MODE_PPTR, MODE_SERIAL, MODE_DPD
    } fbtd_mode_t;

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_AA, SEQ_55, SEQ_NVP, SEQ_STAT, SEQ_LOAD, SEQ_PGM
    } fbtd_seq_t;

    typedef enum logic [1:0] {
        SRC_ARRAY, SRC_STATUS, SRC_ECNT, SRC_PPTR
    } fbtd_src_t;
endpackage

// ==== src/fbtd_sync.sv ====
// Two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ns
module fbtd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Pins and synchronised copy
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    // First stage feeds only the second stage
    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// ==== tb/fbtd_decoder_monitor.sv ====
// Port-level assertions for the flash bus transaction decoder
`timescale 1ns/1ns
module fbtd_decoder_monitor
    import fbtd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Watched inputs
    input wire logic cs_n_i,
    input wire logic [15:0] status_event_i,
    // Watched outputs
    input wire logic dq_oe_n_o,
    input wire logic [ADDR_W-1:0] erase_sector_o,
    input wire logic [15:0] status_o,
    input wire logic legacy_serial_o,
    input wire logic deep_power_down_o,
    input wire logic [1:0] overlay_o,
    input wire logic nv_prog_o,
    input wire logic [15:0] nv_word_o
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Six idle cycles leave room for the two-flop delay on chip select
    a_oe_idle_released: assert property (cs_n_i [*6] |-> dq_oe_n_o)
        else $error("data lines driven while deselected");
    a_nv_one_shot: assert property (nv_prog_o |=> !nv_prog_o)
        else $error("program request longer than one cycle");
    a_nv_word_hold: assert property ($changed(nv_word_o) |-> nv_prog_o)
        else $error("program word moved without a request");
    a_serial_sticky: assert property (legacy_serial_o |=> legacy_serial_o)
        else $error("legacy serial mode left without reset");
    a_dpd_sticky: assert property (deep_power_down_o |=> deep_power_down_o)
        else $error("deep power-down left without reset");
    a_mode_exclusive: assert property ($onehot0({legacy_serial_o,
        deep_power_down_o, overlay_o}))
        else $error("two modes active at once");
    a_quiet_mode_no_prog: assert property ((legacy_serial_o || deep_power_down_o)
        |-> !nv_prog_o)
        else $error("program request in a quiet mode");
    // Nothing may decode once the bus has been idle long enough to drain
    a_idle_no_change: assert property (cs_n_i [*8] |->
        $stable(overlay_o) && $stable(erase_sector_o))
        else $error("mode or sector moved with the bus idle");
    a_status_set_sticky: assert property (status_event_i != 16'h0000
        |=> (status_o & $past(status_event_i)) == $past(status_event_i))
        else $error("status event not captured");
    a_status_idle_keep: assert property (cs_n_i [*8] |->
        ($past(status_o) & ~status_o) == 16'h0000)
        else $error("status bit cleared with the bus idle");
endmodule

bind fbtd_decoder fbtd_decoder_monitor mon_u (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .cs_n_i(cs_n_i),
    .status_event_i(status_event_i),
    .dq_oe_n_o(dq_oe_n_o),
    .erase_sector_o(erase_sector_o),
    .status_o(status_o),
    .legacy_serial_o(legacy_serial_o),
    .deep_power_down_o(deep_power_down_o),
    .overlay_o(overlay_o),
    .nv_prog_o(nv_prog_o),
    .nv_word_o(nv_word_o)
);

// ==== tb/fbtd_decoder_tb.sv ====
// Self-checking bench for the flash bus transaction decoder
`timescale 1ns/1ns
module fbtd_decoder_tb
    import fbtd_pkg::*;
();
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] status_event_i = 16'h0000;
    logic link_clk, cs_n, dq_oe_n, rd_stb, legacy, dpd, nv_prog;
    logic [7:0] dq_h, dq_d;
    logic [1:0] die_sel, ovl;
    logic [1:0] die = 2'b00;
    logic [ADDR_W-1:0] arr_addr, sector;
    logic [15:0] rd_word, status, nv_word, array_data, erase_count;
    logic [15:0] exp_q[$];
    logic [31:0] rnd = 32'h0000_fa05;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;

    // Array and erase counter answer straight from the addresses
    assign array_data = arr_addr[15:0] ^ 16'hc3a5;
    assign erase_count = sector[15:0] + 16'h1111;
    always #25 core_clk_i = ~core_clk_i;

    fbtd_decoder dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk),
        .cs_n_i(cs_n), .dq_i(dq_h), .dq_o(dq_d), .dq_oe_n_o(dq_oe_n),
        .die_select_bits_o(die_sel), .array_addr_o(arr_addr), .array_data_i(array_data),
        .erase_sector_o(sector), .erase_count_i(erase_count), .status_event_i(status_event_i),
        .status_o(status), .legacy_serial_o(legacy), .deep_power_down_o(dpd),
        .overlay_o(ovl), .nv_prog_o(nv_prog), .nv_word_o(nv_word));
    fbtd_host_model host_u (.link_clk_o(link_clk), .cs_n_o(cs_n), .dq_o(dq_h), .dq_i(dq_d),
        .dq_oe_n_i(dq_oe_n), .rd_stb_o(rd_stb), .rd_word_o(rd_word));

    // ****************************************************************
    // Checking and helpers
    // ****************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] act, input logic [47:0] exp);
        n_checks++;
        if (act !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    // Oldest note is taken whenever a read word or program request appears
    task automatic score(input logic [15:0] act);
        logic [15:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
        check(act, e);
    endtask
    always @(posedge rd_stb) score(rd_word);
    // Sampled mid-cycle, where the one-cycle request stands settled
    always @(negedge core_clk_i) if (nv_prog === 1'b1) score(nv_word);
    // A hung handshake ends the run as a failure
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        host_u.xfer(1'b0, {CMD_WRITE, die, a}, d);
    endtask
    // Upper address bits are random because the sequences ignore them
    task automatic wl(input logic [11:0] lo, input logic [7:0] code);
        rnd = lfsr_next(rnd);
        wr({rnd[30:0], lo}, {8'h00, code});
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host_u.xfer(1'b1, {CMD_READ, die, a}, 16'h0000);
    endtask
    task automatic unlock();
        wl(ADDR_UNLOCK1, CODE_UNLOCK1);
        wl(ADDR_UNLOCK2, CODE_UNLOCK2);
    endtask
    task automatic do_reset();
        @(negedge core_clk_i);
        nrst_i = 1'b0;
        repeat (16) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [ADDR_W-1:0] a;
        logic [15:0] w;
        do_reset();
        check({dq_oe_n, ovl, legacy, dpd, status}, {5'h10, 16'h0000});
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr_next(rnd);
            die = rnd[31:30];
            a = {rnd[30:0], rnd[11:0]};
            rd(a, a[15:0] ^ 16'hc3a5);
            check({die_sel, arr_addr}, {rnd[31:30], a});
        end
        // Status capture, read back, wrong-address clear, then real clear
        rnd = lfsr_next(rnd);
        w = rnd[15:0] | 16'h0001;
        @(negedge core_clk_i);
        status_event_i = w;
        @(negedge core_clk_i);
        status_event_i = 16'h0000;
        wl(ADDR_UNLOCK1, CODE_READ_STATUS);
        rd(a, w);
        wl(12'h554, CODE_CLEAR_STATUS);
        check(status, w);
        wl(ADDR_UNLOCK1, CODE_CLEAR_STATUS);
        check(status, 16'h0000);
        wl(rnd[11:0], CODE_EXIT);
        check(ovl, 2'b00);
        // Erase count overlay: read at another address shows the latched sector
        unlock();
        wl(rnd[11:0], CODE_ECNT_ENTRY);
        check(ovl, 2'b01);
        wl(ADDR_UNLOCK1, CODE_LOAD_SECTOR);
        wr(a, 16'h0000);
        check(sector, a);
        rd({a[42:1], ~a[0]}, a[15:0] + 16'h1111);
        wl(rnd[11:0], CODE_EXIT);
        check(ovl, 2'b00);
        rd(a, a[15:0] ^ 16'hc3a5);
        // Pointer overlay, offset 5 is outside the table
        unlock();
        wl(rnd[11:0], CODE_PPTR_ENTRY);
        check(ovl, 2'b10);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr_next(rnd);
            wl(ADDR_UNLOCK1, CODE_PGM_PTR);
            wr(ADDR_W'(i), rnd[15:0]);
            rd(ADDR_W'(i), (i < PTR_COUNT) ? (PTR_RESET & rnd[15:0]) : 16'h0000);
        end
        wl(rnd[11:0], CODE_EXIT);
        check(ovl, 2'b00);
        // Nonvolatile program with the word at a random address
        unlock();
        wl(ADDR_UNLOCK1, CODE_NV_PROGRAM);
        rnd = lfsr_next(rnd);
        exp_q.push_back(rnd[15:0]);
        wr({rnd[30:0], rnd[11:0]}, rnd[15:0]);
        // Broken unlock and a read inside the sequence are both refused
        wl(ADDR_UNLOCK1, CODE_UNLOCK1);
        wl(12'h2ab, CODE_UNLOCK2);
        wl(ADDR_UNLOCK1, CODE_LEGACY_SERIAL);
        unlock();
        rd(a, a[15:0] ^ 16'hc3a5);
        wl(ADDR_UNLOCK1, CODE_LEGACY_SERIAL);
        check(legacy, 1'b0);
        unlock();
        wl(ADDR_UNLOCK1, CODE_LEGACY_SERIAL);
        check(legacy, 1'b1);
        unlock();
        wl(rnd[11:0], CODE_ECNT_ENTRY);
        check(ovl, 2'b00);
        do_reset();
        check(legacy, 1'b0);
        unlock();
        wl(rnd[11:0], CODE_DEEP_POWER_DOWN);
        check(dpd, 1'b1);
        final_report();
    end
endmodule

// ==== tb/fbtd_host_model.sv ====
// Host controller model that runs bus cycles on the flash pins
`timescale 1ns/1ns
module fbtd_host_model (
    // Flash bus pins
    output logic link_clk_o,
    output logic cs_n_o,
    output logic [7:0] dq_o,
    input wire logic [7:0] dq_i,
    input wire logic dq_oe_n_i,
    // Read result
    output logic rd_stb_o,
    output logic [15:0] rd_word_o
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    logic [7:0] last_b = 8'h00;

    // Link clock stands still between cycles, at whatever level it ended
    initial begin
        link_clk_o = 1'b0;
        cs_n_o = 1'b1;
        dq_o = 8'h00;
        rd_stb_o = 1'b0;
        rd_word_o = 16'h0000;
    end

    // Data settles half way through the half period, so it is stable at the edge
    task automatic edge_byte(input logic [7:0] b);
        dq_o = b;
        last_b = b;
        #100;
        link_clk_o = ~link_clk_o;
        #100;
    endtask

    // Command word high byte first, then data word high byte first
    task automatic xfer(input logic rd, input logic [47:0] cw, input logic [15:0] wd);
        cs_n_o = 1'b0;
        #100;
        for (int i = 5; i >= 0; i--) begin
            edge_byte(cw[8*i +: 8]);
        end
        if (rd) begin
            edge_byte(~last_b);
            // Released line shows the inverse, never a stale byte
            dq_o = ~last_b;
            #300;
            rd_word_o[15:8] = (dq_oe_n_i === 1'b0) ? dq_i : 8'hxx;
            link_clk_o = ~link_clk_o;
            #300;
            rd_word_o[7:0] = (dq_oe_n_i === 1'b0) ? dq_i : 8'hxx;
            link_clk_o = ~link_clk_o;
            #150;
            rd_stb_o = 1'b1;
        end else begin
            edge_byte(wd[15:8]);
            edge_byte(wd[7:0]);
            #50;
        end
        cs_n_o = 1'b1;
        dq_o = ~last_b;
        #50;
        rd_stb_o = 1'b0;
        #350;
    endtask
endmodule
